// >>> rtl/rcc_pkg.sv
// Constants, field layouts and state codes for the calendar clock block.
// Assumes an 8-bit register port with a 12-bit address, clocked by mclk.
//
// Summary of operation
// - Alarm hours: tens bits 5-4, ones 3-0
// - Alarm minutes: tens bits 6-4, bit7 zero
// - Alarm seconds: tens bits 6-4, bit7 zero
// - Alarm hours writable only while unlocked
// - Locked: ignore enable and time window writes
// - Every value is BCD, four bits per digit
// - Count source: crystal or internal RC strap
// - 23:59:59 wraps to midnight, carries into day
// - After December last day, wrap 01/01, carry year
// - Weekday steps 6 to 0, no carry
// - Year wraps 99 to 00, no carry
// - Ones digit carries at ten, not sixteen
// - Day limit 31 or 30 by month
// - February 29 in leap years, else 28
// - Leap year: year divisible by four
// - Counting resumes from newly written value
// - Minutes/seconds write clears the prescaler
// - Writes take effect in same cycle
// - Half-second bit cleared by seconds write
// - Rollover pending flag at config bit 4
// - Unlock set only right after 55h, AAh
// - High byte access decrements pointer, stops 00
`default_nettype none

package rcc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_ALRM_LO = 12'h0f8e;
    localparam logic [11:0] OFS_ALRM_HI = 12'h0f8f;
    localparam logic [11:0] OFS_TIME_LO = 12'h0f98;
    localparam logic [11:0] OFS_TIME_HI = 12'h0f99;
    localparam logic [11:0] OFS_CFG = 12'h0f9a;
    localparam logic [11:0] OFS_ALRM_CFG = 12'h0f9b;
    localparam logic [11:0] OFS_UNLOCK = 12'h0f9c;

    // ----------------------------------------------------------------
    // Config register fields
    // ----------------------------------------------------------------
    localparam int unsigned CFG_EN_BIT = 7;
    localparam int unsigned CFG_UNLOCK_BIT = 5;
    localparam int unsigned CFG_SYNC_BIT = 4;
    localparam int unsigned CFG_HALF_BIT = 3;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    localparam logic [1:0] PTR_MINUTES_SECONDS_PAIR = 2'h0;
    localparam logic [1:0] PTR_WDHR = 2'h1;
    localparam logic [1:0] PTR_MTHDAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;

    // ----------------------------------------------------------------
    // Field masks and limits, all BCD
    // ----------------------------------------------------------------
    localparam logic [7:0] SEC_MASK = 8'h7f;
    localparam logic [7:0] MIN_MASK = 8'h7f;
    localparam logic [7:0] HR_MASK = 8'h3f;
    localparam logic [7:0] WD_MASK = 8'h07;
    localparam logic [7:0] DAY_MASK = 8'h3f;
    localparam logic [7:0] MTH_MASK = 8'h1f;
    localparam logic [7:0] YR_MASK = 8'hff;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HR_LAST = 8'h23;
    localparam logic [7:0] WD_LAST = 8'h06;
    localparam logic [7:0] MTH_LAST = 8'h12;
    localparam logic [7:0] YR_LAST = 8'h99;
    localparam logic [7:0] DAY_LAST_31 = 8'h31;
    localparam logic [7:0] DAY_LAST_30 = 8'h30;
    localparam logic [7:0] DAY_LAST_29 = 8'h29;
    localparam logic [7:0] DAY_LAST_28 = 8'h28;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;

    // ----------------------------------------------------------------
    // Timing: source ticks per second and rollover guard band
    // ----------------------------------------------------------------
    localparam int unsigned SRC_FREQ_HZ = 32768;
    localparam int unsigned PRESC_W = 15;
    localparam logic [14:0] PRESC_LAST = 15'(SRC_FREQ_HZ - 1);
    localparam logic [14:0] SYNC_TICKS = 15'h0020;
    localparam int unsigned HALF_BIT = 14;

    typedef enum logic [1:0] {
        UNL_IDLE = 2'h0,
        UNL_KEY1 = 2'h1,
        UNL_ARMED = 2'h3
    } rcc_unlock_e;

endpackage

`default_nettype wire

// >>> rtl/rcc_bcd_step.sv
// Two-digit BCD incrementer with a settable last value and wrap value.
// Purely combinational; the caller decides when the step is taken.
`timescale 1ns/1ns
`default_nettype none

module rcc_bcd_step (
    input wire logic [7:0] cur,
    input wire logic [7:0] last,
    input wire logic [7:0] first,
    output logic [7:0] nxt,
    output logic wrap
);

    always_comb begin
        wrap = (cur == last);
        if (wrap) begin
            nxt = first;
        end else if (cur[3:0] >= 4'h9) begin
            nxt = {4'(cur[7:4] + 4'h1), 4'h0};
        end else begin
            nxt = {cur[7:4], 4'(cur[3:0] + 4'h1)};
        end
    end

endmodule // rcc_bcd_step

`default_nettype wire

// >>> rtl/rcc_calendar.sv
// Calendar clock: BCD time/date counters, alarm time values, write lock.
// Assumes the source clock pins and the register port are synchronous to mclk.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module rcc_calendar
    import rcc_pkg::*;
#(
    parameter logic [14:0] PRESC_LAST_P = PRESC_LAST,
    parameter logic [14:0] SYNC_TICKS_P = SYNC_TICKS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic xtal_clk_in,
    input wire logic rc_clk_in,
    input wire logic clock_source_select,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    output logic [7:0] bus_rdata
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic src_sel_q, strap_taken_q, src_prev_q, src_in, src_edge;
    logic [14:0] presc_q;
    logic sec_tick, sync_q;
    logic enable_q, unlock_q;
    rcc_unlock_e unl_q;
    logic [1:0] tptr_q, aptr_q;
    logic [7:0] sec_q, min_q, hr_q, wd_q, day_q, mth_q, yr_q;
    logic [7:0] al_hr_q, al_min_q, al_sec_q;
    logic [7:0] sec_n, min_n, hr_n, wd_n, day_n, mth_n, yr_n;
    logic sec_w, min_w, hr_w, day_w, mth_w;
    logic [7:0] day_last;
    logic leap;
    logic min_inc, hr_inc, day_inc, mth_inc, yr_inc;
    logic cfg_wr, acfg_wr, t_wr_lo, t_wr_hi, t_hi_acc, a_hi_acc;
    logic a_wr_lo, a_wr_hi, minutes_seconds_pair_wr;
    logic [7:0] rdata_d, rdata_q;

    // ----------------------------------------------------------------
    // Source selection and tick
    // ----------------------------------------------------------------
    // Strap is caught once after reset release, never under reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            src_sel_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            src_sel_q <= clock_source_select;
            strap_taken_q <= 1'b1;
        end
    end

    assign src_in = src_sel_q ? rc_clk_in : xtal_clk_in;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_in;
        end
    end

    assign src_edge = src_in & ~src_prev_q & strap_taken_q;

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------
    assign cfg_wr = bus_we && (bus_addr == OFS_CFG);
    assign acfg_wr = bus_we && (bus_addr == OFS_ALRM_CFG);
    assign t_wr_lo = bus_we && (bus_addr == OFS_TIME_LO) && unlock_q;
    assign t_wr_hi = bus_we && (bus_addr == OFS_TIME_HI) && unlock_q;
    assign a_wr_lo = bus_we && (bus_addr == OFS_ALRM_LO);
    assign a_wr_hi = bus_we && (bus_addr == OFS_ALRM_HI);
    assign t_hi_acc = (bus_we || bus_re) && (bus_addr == OFS_TIME_HI);
    assign a_hi_acc = (bus_we || bus_re) && (bus_addr == OFS_ALRM_HI);
    assign minutes_seconds_pair_wr = (t_wr_lo || t_wr_hi) && (tptr_q == PTR_MINUTES_SECONDS_PAIR);

    // ----------------------------------------------------------------
    // Prescaler, half-second bit and rollover guard
    // ----------------------------------------------------------------
    assign sec_tick = enable_q && src_edge && (presc_q == PRESC_LAST_P);

    // Half-second bit reads the prescaler's upper half, so one clear serves both
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            presc_q <= '0;
        end else if (minutes_seconds_pair_wr) begin
            presc_q <= '0;
        end else if (enable_q && src_edge) begin
            presc_q <= (presc_q == PRESC_LAST_P) ? '0 : 15'(presc_q + 15'h0001);
        end
    end

    // Guard band ahead of the second boundary
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= enable_q && (presc_q >= 15'(PRESC_LAST_P - SYNC_TICKS_P));
        end
    end

    // ----------------------------------------------------------------
    // Digit stepping
    // ----------------------------------------------------------------
    rcc_bcd_step u_sec (.cur(sec_q), .last(SEC_LAST), .first(BCD_ZERO),
        .nxt(sec_n), .wrap(sec_w));
    rcc_bcd_step u_min (.cur(min_q), .last(MIN_LAST), .first(BCD_ZERO),
        .nxt(min_n), .wrap(min_w));
    rcc_bcd_step u_hr (.cur(hr_q), .last(HR_LAST), .first(BCD_ZERO),
        .nxt(hr_n), .wrap(hr_w));
    rcc_bcd_step u_wd (.cur(wd_q), .last(WD_LAST), .first(BCD_ZERO),
        .nxt(wd_n), .wrap());
    rcc_bcd_step u_day (.cur(day_q), .last(day_last), .first(BCD_ONE),
        .nxt(day_n), .wrap(day_w));
    rcc_bcd_step u_mth (.cur(mth_q), .last(MTH_LAST), .first(BCD_ONE),
        .nxt(mth_n), .wrap(mth_w));
    rcc_bcd_step u_yr (.cur(yr_q), .last(YR_LAST), .first(BCD_ZERO),
        .nxt(yr_n), .wrap());

    // Year BCD divisible by four; valid for the 2000-2099 span only
    assign leap = yr_q[4] ? (yr_q[3:0] == 4'h2 || yr_q[3:0] == 4'h6)
        : (yr_q[3:0] == 4'h0 || yr_q[3:0] == 4'h4 || yr_q[3:0] == 4'h8);

    always_comb begin
        unique case (mth_q)
            8'h02: day_last = leap ? DAY_LAST_29 : DAY_LAST_28;
            8'h04, 8'h06, 8'h09, 8'h11: day_last = DAY_LAST_30;
            default: day_last = DAY_LAST_31;
        endcase
    end

    assign min_inc = sec_tick && sec_w;
    assign hr_inc = min_inc && min_w;
    assign day_inc = hr_inc && hr_w;
    assign mth_inc = day_inc && day_w;
    assign yr_inc = mth_inc && mth_w;

    // ----------------------------------------------------------------
    // Time of day; a write overrides a same-cycle step
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_q <= BCD_ZERO;
            min_q <= BCD_ZERO;
            hr_q <= BCD_ZERO;
        end else begin
            if (t_wr_lo && tptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                sec_q <= bus_wdata & SEC_MASK;
            end else if (sec_tick) begin
                sec_q <= sec_n;
            end
            if (t_wr_hi && tptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                min_q <= bus_wdata & MIN_MASK;
            end else if (min_inc) begin
                min_q <= min_n;
            end
            if (t_wr_lo && tptr_q == PTR_WDHR) begin
                hr_q <= bus_wdata & HR_MASK;
            end else if (hr_inc) begin
                hr_q <= hr_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // Date
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wd_q <= BCD_ZERO;
            day_q <= BCD_ONE;
            mth_q <= BCD_ONE;
            yr_q <= BCD_ZERO;
        end else begin
            if (t_wr_hi && tptr_q == PTR_WDHR) begin
                wd_q <= bus_wdata & WD_MASK;
            end else if (day_inc) begin
                wd_q <= wd_n;
            end
            if (t_wr_lo && tptr_q == PTR_MTHDAY) begin
                day_q <= bus_wdata & DAY_MASK;
            end else if (day_inc) begin
                day_q <= day_n;
            end
            if (t_wr_hi && tptr_q == PTR_MTHDAY) begin
                mth_q <= bus_wdata & MTH_MASK;
            end else if (mth_inc) begin
                mth_q <= mth_n;
            end
            if (t_wr_lo && tptr_q == PTR_YEAR) begin
                yr_q <= bus_wdata & YR_MASK;
            end else if (yr_inc) begin
                yr_q <= yr_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // Alarm time values
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            al_hr_q <= BCD_ZERO;
            al_min_q <= BCD_ZERO;
            al_sec_q <= BCD_ZERO;
        end else begin
            if (a_wr_lo && aptr_q == PTR_WDHR && unlock_q) begin
                al_hr_q <= bus_wdata & HR_MASK;
            end
            if (a_wr_hi && aptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                al_min_q <= bus_wdata & MIN_MASK;
            end
            if (a_wr_lo && aptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                al_sec_q <= bus_wdata & SEC_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Window pointers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tptr_q <= PTR_MINUTES_SECONDS_PAIR;
            aptr_q <= PTR_MINUTES_SECONDS_PAIR;
        end else begin
            if (cfg_wr) begin
                tptr_q <= bus_wdata[1:0];
            end else if (t_hi_acc && tptr_q != PTR_MINUTES_SECONDS_PAIR) begin
                tptr_q <= 2'(tptr_q - 2'h1);
            end
            if (acfg_wr) begin
                aptr_q <= bus_wdata[1:0];
            end else if (a_hi_acc && aptr_q != PTR_MINUTES_SECONDS_PAIR) begin
                aptr_q <= 2'(aptr_q - 2'h1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Unlock sequence and config bits
    // ----------------------------------------------------------------
    // Any other write between the keys aborts; the armed state lasts one cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unl_q <= UNL_IDLE;
        end else if (bus_we && bus_addr == OFS_UNLOCK && bus_wdata == UNLOCK_KEY1) begin
            unl_q <= UNL_KEY1;
        end else begin
            unique case (unl_q)
                UNL_IDLE: unl_q <= UNL_IDLE;
                UNL_KEY1: begin
                    if (bus_we && bus_addr == OFS_UNLOCK && bus_wdata == UNLOCK_KEY2) begin
                        unl_q <= UNL_ARMED;
                    end else if (bus_we) begin
                        unl_q <= UNL_IDLE;
                    end
                end
                UNL_ARMED: unl_q <= UNL_IDLE;
                default: unl_q <= UNL_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_q <= 1'b0;
            enable_q <= 1'b0;
        end else if (cfg_wr) begin
            if (!bus_wdata[CFG_UNLOCK_BIT]) begin
                unlock_q <= 1'b0;
            end else if (unl_q == UNL_ARMED) begin
                unlock_q <= 1'b1;
            end
            if (unlock_q) begin
                enable_q <= bus_wdata[CFG_EN_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port; data stand only in the cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        unique case (bus_addr)
            OFS_TIME_LO: begin
                unique case (tptr_q)
                    PTR_MINUTES_SECONDS_PAIR: rdata_d = sec_q & SEC_MASK;
                    PTR_WDHR: rdata_d = hr_q & HR_MASK;
                    PTR_MTHDAY: rdata_d = day_q & DAY_MASK;
                    PTR_YEAR: rdata_d = yr_q;
                endcase
            end
            OFS_TIME_HI: begin
                unique case (tptr_q)
                    PTR_MINUTES_SECONDS_PAIR: rdata_d = min_q & MIN_MASK;
                    PTR_WDHR: rdata_d = wd_q & WD_MASK;
                    PTR_MTHDAY: rdata_d = mth_q & MTH_MASK;
                    PTR_YEAR: rdata_d = 8'h00;
                endcase
            end
            OFS_ALRM_LO: begin
                if (aptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                    rdata_d = al_sec_q & SEC_MASK;
                end else if (aptr_q == PTR_WDHR) begin
                    rdata_d = al_hr_q & HR_MASK;
                end
            end
            OFS_ALRM_HI: begin
                if (aptr_q == PTR_MINUTES_SECONDS_PAIR) begin
                    rdata_d = al_min_q & MIN_MASK;
                end
            end
            OFS_CFG: begin
                rdata_d[CFG_EN_BIT] = enable_q;
                rdata_d[CFG_UNLOCK_BIT] = unlock_q;
                rdata_d[CFG_SYNC_BIT] = sync_q;
                rdata_d[CFG_HALF_BIT] = presc_q > (PRESC_LAST_P >> 1);
                rdata_d[1:0] = tptr_q;
            end
            OFS_ALRM_CFG: rdata_d[1:0] = aptr_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= bus_re ? rdata_d : 8'h00;
        end
    end

    assign bus_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    alarm_hr_read_a: assert property (
        (bus_re && bus_addr == OFS_ALRM_LO && aptr_q == PTR_WDHR)
        |=> (bus_rdata[7:6] == 2'b00 && bus_rdata == $past(al_hr_q)))
        else $error("alarm hours read wrong");
    alarm_min_read_a: assert property (
        (bus_re && bus_addr == OFS_ALRM_HI && aptr_q == PTR_MINUTES_SECONDS_PAIR) |=> !bus_rdata[7])
        else $error("alarm minutes bit 7 set");
    alarm_sec_read_a: assert property (
        (bus_re && bus_addr == OFS_ALRM_LO && aptr_q == PTR_MINUTES_SECONDS_PAIR) |=> !bus_rdata[7])
        else $error("alarm seconds bit 7 set");
    alarm_hr_lock_a: assert property (
        (bus_we && bus_addr == OFS_ALRM_LO && !unlock_q) |=> $stable(al_hr_q))
        else $error("alarm hours written while locked");
    enable_lock_a: assert property (
        (cfg_wr && !unlock_q) |=> $stable(enable_q))
        else $error("enable changed while locked");
    midnight_wrap_a: assert property (
        (sec_tick && sec_q == SEC_LAST && min_q == MIN_LAST && hr_q == HR_LAST
            && !t_wr_lo && !t_wr_hi)
        |=> (sec_q == BCD_ZERO && min_q == BCD_ZERO && hr_q == BCD_ZERO))
        else $error("midnight wrap wrong");
    weekday_range_a: assert property (
        (day_inc && wd_q == WD_LAST && !t_wr_hi) |=> (wd_q == BCD_ZERO))
        else $error("weekday did not wrap to 0");
    presc_clear_a: assert property (
        minutes_seconds_pair_wr |=> (presc_q == '0 && !presc_q[HALF_BIT]))
        else $error("prescaler not cleared");
    unlock_seq_a: assert property (
        $rose(unlock_q) |-> ($past(unl_q) == UNL_ARMED && $past(cfg_wr)))
        else $error("unlock set without key sequence");
    pointer_dec_a: assert property (
        (t_hi_acc && tptr_q != PTR_MINUTES_SECONDS_PAIR) |=> (tptr_q == 2'($past(tptr_q) - 2'h1)))
        else $error("time pointer not decremented");

endmodule // rcc_calendar

`default_nettype wire

// >>> testbench/rcc_host_model.sv
// Host side of the calendar block: register bus master and source pins.
// Assumes mclk from the bench; every pin changes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module rcc_host_model
    import rcc_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] bus_rdata,
    output logic xtal_clk_in,
    output logic rc_clk_in,
    output logic [11:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_we,
    output logic bus_re
);
    initial begin
        {xtal_clk_in, rc_clk_in, bus_we, bus_re} = 4'h0;
        bus_addr = 12'h000;
        bus_wdata = 8'h00;
    end

    // Unselected source runs fast, so any leak into the counter shows
    always @(posedge mclk) rc_clk_in <= ~rc_clk_in;

    // Strobes stay up into the next call, so writes go back to back
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_re <= 1'b0;
        bus_we <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_we <= 1'b0;
        bus_re <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_re <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // Key pair, then the config write in the very next cycle
    task automatic unlock;
        wr(OFS_UNLOCK, UNLOCK_KEY1);
        wr(OFS_UNLOCK, UNLOCK_KEY2);
        wr(OFS_CFG, 8'h20);
    endtask

    task automatic tick(input int n);
        @(posedge mclk);
        bus_we <= 1'b0;
        repeat (n) begin
            xtal_clk_in <= 1'b1;
            repeat (2) @(posedge mclk);
            xtal_clk_in <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule // rcc_host_model

`default_nettype wire

// >>> testbench/rcc_calendar_test.sv
// Self-checking bench: integer calendar model against the register port.
// Assumes the small prescaler below; six-tick runs reach the guard band, a four-tick run from a cleared prescaler stays under it.
`timescale 1ns/1ns
`default_nettype none

module rcc_calendar_test;
    import rcc_pkg::*;
    logic mclk, reset_n, sel;
    logic xtal, rc, we, re;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, d;
    int mismatches, checks_done, seed;
    int tm[7];
    int HI_IX[4] = '{1, 1, 3, 5};
    int cases[6][7] = '{'{99, 12, 31, 6, 23, 59, 59}, '{4, 2, 28, 2, 23, 59, 59},
        '{1, 2, 28, 3, 23, 59, 59}, '{4, 2, 29, 4, 23, 59, 59},
        '{5, 4, 30, 5, 23, 59, 59}, '{5, 8, 19, 3, 9, 9, 9}};

    rcc_calendar #(.PRESC_LAST_P(15'h0007), .SYNC_TICKS_P(15'h0002)) DUT (
        .mclk(mclk), .reset_n(reset_n), .xtal_clk_in(xtal), .rc_clk_in(rc),
        .clock_source_select(sel), .bus_addr(addr), .bus_wdata(wdata),
        .bus_we(we), .bus_re(re), .bus_rdata(rdata));
    rcc_host_model host (.mclk(mclk), .bus_rdata(rdata), .xtal_clk_in(xtal),
        .rc_clk_in(rc), .bus_addr(addr), .bus_wdata(wdata), .bus_we(we), .bus_re(re));

    // ----------------------------------------------------------------
    // Checking and model
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction

    function automatic int dim(input int m, input int y);
        if (m == 2) return (y % 4 == 0) ? 29 : 28;
        if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
        return 31;
    endfunction

    task automatic step;
        tm[6]++;
        if (tm[6] == 60) begin
            tm[6] = 0;
            tm[5]++;
        end
        if (tm[5] == 60) begin
            tm[5] = 0;
            tm[4]++;
        end
        if (tm[4] == 24) begin
            tm[4] = 0;
            tm[3] = (tm[3] + 1) % 7;
            tm[2]++;
        end
        if (tm[2] > dim(tm[1], tm[0])) begin
            tm[2] = 1;
            tm[1]++;
        end
        if (tm[1] == 13) begin
            tm[1] = 1;
            tm[0] = (tm[0] + 1) % 100;
        end
    endtask

    // Pointer starts at 3 and walks down on each high-byte access until it stops at 0
    task automatic set_time;
        host.wr(OFS_CFG, 8'ha3);
        for (int i = 0; i < 4; i++) begin
            host.wr(OFS_TIME_LO, bcd(tm[2 * i]));
            host.wr(OFS_TIME_HI, bcd(tm[HI_IX[i]]));
        end
    endtask

    task automatic check_time;
        host.wr(OFS_CFG, 8'ha3);
        for (int i = 0; i < 4; i++) begin
            host.rd(OFS_TIME_LO, d);
            chk(d, bcd(tm[2 * i]));
            host.rd(OFS_TIME_HI, d);
            chk(d, i == 0 ? 8'h00 : bcd(tm[HI_IX[i]]));
        end
        host.rd(OFS_TIME_HI, d);
        chk(d, bcd(tm[5]));
        host.rd(OFS_TIME_LO, d);
        chk(d, bcd(tm[6]));
    endtask

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        results();
    end

    initial begin
        seed = 32'h35e3;
        reset_n = 1'b0;
        sel = 1'b0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        host.wr(OFS_TIME_LO, 8'h30);
        host.wr(OFS_CFG, 8'h80);
        host.wr(OFS_ALRM_CFG, 8'h01);
        host.wr(OFS_ALRM_LO, 8'h12);
        host.rd(OFS_ALRM_LO, d);
        chk(d, 8'h00);
        host.rd(OFS_TIME_LO, d);
        chk(d, 8'h00);
        host.rd(OFS_CFG, d);
        chk(d, 8'h00);
        host.wr(OFS_ALRM_CFG, 8'h00);
        host.wr(OFS_ALRM_LO, 8'hb7);
        host.wr(OFS_ALRM_HI, 8'hd9);
        host.rd(OFS_ALRM_LO, d);
        chk(d, 8'h37);
        host.rd(OFS_ALRM_HI, d);
        chk(d, 8'h59);
        // Any write between the keys must abort the sequence
        host.wr(OFS_UNLOCK, 8'h55);
        host.wr(OFS_ALRM_CFG, 8'h00);
        host.wr(OFS_UNLOCK, 8'haa);
        host.wr(OFS_CFG, 8'h20);
        host.rd(OFS_CFG, d);
        chk(d, 8'h00);
        host.unlock();
        host.rd(OFS_CFG, d);
        chk(d, 8'h20);
        host.wr(OFS_ALRM_CFG, 8'h01);
        host.wr(OFS_ALRM_LO, 8'he3);
        host.rd(OFS_ALRM_LO, d);
        chk(d, 8'h23);
        host.rd(OFS_ALRM_HI, d);
        host.rd(OFS_ALRM_CFG, d);
        chk(d & 8'h03, 8'h00);
        $display("test lock done");
        host.wr(OFS_CFG, 8'ha0);
        for (int c = 0; c < 10; c++) begin
            if (c < 6) tm = cases[c];
            else begin
                tm[0] = ($random(seed) & 32'h7fff) % 100;
                tm[1] = 1 + ($random(seed) & 32'h7fff) % 12;
                tm[2] = dim(tm[1], tm[0]);
                tm[3] = ($random(seed) & 32'h7fff) % 7;
                tm[4] = 23;
                tm[5] = 59;
                tm[6] = 59;
            end
            host.tick(6);
            host.rd(OFS_CFG, d);
            chk(d & 8'h10, 8'h10);
            chk(d & 8'h08, 8'h08);
            set_time();
            host.rd(OFS_CFG, d);
            chk(d & 8'h18, 8'h00);
            host.tick(4);
            check_time();
            host.tick(4);
            step();
            check_time();
            $display("test date %0d done", c);
        end
        // Mid-run reset onto the RC strap: 20 source edges give two seconds
        sel <= 1'b1;
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        host.unlock();
        host.wr(OFS_CFG, 8'ha0);
        host.tick(0);
        repeat (40) @(posedge mclk);
        host.rd(OFS_TIME_LO, d);
        chk(d, 8'h02);
        $display("test source done");
        results();
    end
endmodule // rcc_calendar_test

`default_nettype wire
